// file: src/nnp_pkg.sv
// shared constants, types and decode functions of the negate/nop/pop executor
package nnp_pkg;

	localparam int DATA_W      = 8;
	localparam int ADDR_W      = 12;
	localparam int BANK_W      = 4;
	localparam int PC_W        = 21;
	localparam int INSTR_W     = 16;
	localparam int STACK_DEPTH = 31;
	localparam int APB_AW      = 12;
	localparam int FLAG_W      = 5;
	localparam int EVT_W       = 3;

	// opcode patterns, address constants and program counter step
	localparam logic [6:0]         NEG_OPC   = 7'h36;
	localparam logic [INSTR_W-1:0] POP_OPC   = 16'h0006;
	localparam logic [INSTR_W-1:0] NOP_ZERO  = 16'h0000;
	localparam logic [3:0]         NOP_HI    = 4'hf;
	localparam logic [7:0]         IDX_LIMIT = 8'h5f;
	localparam logic [BANK_W-1:0]  ACC_HI    = 4'hf;
	localparam logic [BANK_W-1:0]  ACC_LO    = 4'h0;
	localparam logic [PC_W-1:0]    PC_STEP   = 21'h000002;

	// register byte offsets
	localparam logic [APB_AW-1:0] OFS_CTRL   = 12'h000;
	localparam logic [APB_AW-1:0] OFS_BANK   = 12'h004;
	localparam logic [APB_AW-1:0] OFS_INDEX  = 12'h008;
	localparam logic [APB_AW-1:0] OFS_STATUS = 12'h00c;
	localparam logic [APB_AW-1:0] OFS_EVENT  = 12'h010;
	localparam logic [APB_AW-1:0] OFS_PC     = 12'h014;
	localparam logic [APB_AW-1:0] OFS_DEPTH  = 12'h018;
	localparam logic [APB_AW-1:0] OFS_TOP    = 12'h01c;

	// field positions
	localparam int CTRL_EXT  = 0;
	localparam int FLG_C     = 0;
	localparam int FLG_DIGIT = 1;
	localparam int FLG_Z     = 2;
	localparam int FLG_OVFL  = 3;
	localparam int FLG_N     = 4;
	localparam int EVT_BAD   = 0;
	localparam int EVT_UNDER = 1;
	localparam int EVT_OVER  = 2;

	// reset values
	localparam logic              CTRL_RST   = 1'b0;
	localparam logic [BANK_W-1:0] BANK_RST   = 4'h0;
	localparam logic [ADDR_W-1:0] INDEX_RST  = 12'h000;
	localparam logic [FLAG_W-1:0] STATUS_RST = 5'h00;
	localparam logic [EVT_W-1:0]  EVENT_RST  = 3'h0;
	localparam logic [PC_W-1:0]   PC_RST     = 21'h000000;

	typedef enum logic [1:0] {
		ST_Q1 = 2'b00,
		ST_Q2 = 2'b01,
		ST_Q3 = 2'b11,
		ST_Q4 = 2'b10
	} nnp_state_e;

	typedef enum logic [1:0] {
		OP_NOP = 2'b00,
		OP_NEG = 2'b01,
		OP_POP = 2'b10,
		OP_BAD = 2'b11
	} nnp_op_e;

	function automatic nnp_op_e nnp_decode(input logic [INSTR_W-1:0] w);
		nnp_op_e op;
		op = OP_BAD;
		if (w[15:9] == NEG_OPC)
			op = OP_NEG;
		else if (w == POP_OPC)
			op = OP_POP;
		else if (w == NOP_ZERO || w[15:12] == NOP_HI)
			op = OP_NOP;
		return op;
	endfunction

	function automatic logic [ADDR_W-1:0] nnp_form_addr(
		input logic              a,
		input logic [7:0]        f,
		input logic              ext,
		input logic [BANK_W-1:0] bank,
		input logic [ADDR_W-1:0] index
	);
		logic [ADDR_W-1:0] addr;
		addr = {ACC_LO, f};
		if (a)
			addr = {bank, f};
		else if (ext && f <= IDX_LIMIT)
			addr = index + {ACC_LO, f};
		else if (f > IDX_LIMIT)
			addr = {ACC_HI, f};
		return addr;
	endfunction

endpackage

// file: src/nnp_negate.sv
// two's complement negation of a byte with its arithmetic flags
`timescale 1ns/1ns
`default_nettype none
module nnp_negate
	import nnp_pkg::*;
(
	input  wire logic [DATA_W-1:0] operand_i,
	output logic      [DATA_W-1:0] result_o,
	output logic      [FLAG_W-1:0] flags_o
);
	logic [DATA_W:0]   sum;
	logic [4:0]        low_sum;
	logic [DATA_W-1:0] inv;

	always_comb begin
		inv      = ~operand_i;
		sum      = {1'b0, inv} + 9'h001;
		low_sum  = {1'b0, inv[3:0]} + 5'h01;
		result_o = sum[DATA_W-1:0];
		flags_o[FLG_C]  = sum[DATA_W];
		flags_o[FLG_DIGIT] = low_sum[4];
		flags_o[FLG_Z]  = (sum[DATA_W-1:0] == 8'h00);
		flags_o[FLG_N]  = sum[DATA_W-1];
		flags_o[FLG_OVFL] = ~inv[DATA_W-1] & sum[DATA_W-1];
	end
endmodule
`default_nettype wire

// file: src/nnp_rstack.sv
// return stack memory with registered top entry
`timescale 1ns/1ns
`default_nettype none
module nnp_rstack #(
	parameter int DEPTH = 31,
	parameter int WIDTH = 21,
	localparam int CNT_W = $clog2(DEPTH + 1)
) (
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic             push_i,
	input  wire logic             pop_i,
	input  wire logic [WIDTH-1:0] data_i,
	output logic      [WIDTH-1:0] top_o,
	output logic      [CNT_W-1:0] count_o,
	output logic                  full_o,
	output logic                  empty_o
);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [CNT_W-1:0] count_reg;
	logic [WIDTH-1:0] top_reg;
	logic             do_push;
	logic             do_pop;

	if (DEPTH < 2) begin : g_chk
		$error("nnp_rstack needs DEPTH of at least 2");
	end

	assign full_o  = (count_reg == CNT_W'(DEPTH));
	assign empty_o = (count_reg == '0);
	assign do_push = push_i && !full_o;
	assign do_pop  = pop_i && !empty_o && !push_i;
	assign top_o   = top_reg;
	assign count_o = count_reg;

	always_ff @(posedge clk_i) begin
		if (do_push)
			mem_reg[count_reg] <= data_i;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			count_reg <= '0;
		else if (do_push)
			count_reg <= count_reg + CNT_W'(1);
		else if (do_pop)
			count_reg <= count_reg - CNT_W'(1);
	end

	// entry below the top becomes the new top on a pop
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			top_reg <= '0;
		else if (do_push)
			top_reg <= data_i;
		else if (do_pop)
			top_reg <= (count_reg >= CNT_W'(2)) ? mem_reg[count_reg - CNT_W'(2)] : '0;
	end
endmodule
`default_nettype wire

// file: src/nnp_exec.sv
// executor for negate-byte, no-operation and return-stack discard instructions
//
// Functional notes
// - decode negate opcode, bank bit, byte address
// - result is inverted byte plus one
// - write back same address in fourth quarter
// - negate updates N, overflow, C, digit carry, Z
// - bank bit picks access bank or bank
// - indexed offset when a=0, extended, f<=5Fh
// - decode discard opcode, one cycle, no flags
// - discard top, lower entry becomes top
`timescale 1ns/1ns
`default_nettype none
module nnp_exec
	import nnp_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH
) (
	input  wire logic               CLK_SYS_I,
	input  wire logic               RSTN_I,
	input  wire logic               PSEL_I,
	input  wire logic               PENABLE_I,
	input  wire logic               PWRITE_I,
	input  wire logic [APB_AW-1:0]  PADDR_I,
	input  wire logic [31:0]        PWDATA_I,
	output logic      [31:0]        PRDATA_O,
	output logic                    PREADY_O,
	output logic                    PSLVERR_O,
	input  wire logic               INSTR_VALID_I,
	input  wire logic [INSTR_W-1:0] INSTR_I,
	output logic                    INSTR_READY_O,
	output logic      [ADDR_W-1:0]  DMEM_ADDR_O,
	output logic                    DMEM_RD_O,
	input  wire logic [DATA_W-1:0]  DMEM_RDATA_I,
	output logic                    DMEM_WR_O,
	output logic      [DATA_W-1:0]  DMEM_WDATA_O,
	output logic                    DONE_O
);
	localparam int CNT_W = $clog2(DEPTH + 1);

	if (DEPTH < 2 || DEPTH > 255) begin : g_chk
		$error("nnp_exec DEPTH out of range");
	end

	nnp_state_e         state_reg;
	nnp_state_e         state_next;
	nnp_op_e            op_reg;
	logic [INSTR_W-1:0] instr_reg;
	logic               ready_reg;
	logic               done_reg;
	logic [ADDR_W-1:0]  addr_reg;
	logic               rd_reg;
	logic               wr_reg;
	logic [DATA_W-1:0]  wdata_reg;
	logic [FLAG_W-1:0]  flag_pend_reg;
	logic [FLAG_W-1:0]  flags_reg;
	logic               ext_reg;
	logic [BANK_W-1:0]  bank_reg;
	logic [ADDR_W-1:0]  index_reg;
	logic [EVT_W-1:0]   evt_reg;
	logic [PC_W-1:0]    pc_reg;
	logic               pready_reg;
	logic               pslverr_reg;
	logic [31:0]        prdata_reg;
	logic               take;
	logic               apb_go;
	logic               wr_commit;
	logic [DATA_W-1:0]  neg_result;
	logic [FLAG_W-1:0]  neg_flags;
	logic               push;
	logic               pop;
	logic [PC_W-1:0]    stk_top;
	logic [CNT_W-1:0]   stk_count;
	logic               stk_full;
	logic               stk_empty;
	logic [EVT_W-1:0]   evt_set;

	function automatic logic reg_hit(input logic [APB_AW-1:0] a);
		return a == OFS_CTRL || a == OFS_BANK || a == OFS_INDEX || a == OFS_STATUS ||
			a == OFS_EVENT || a == OFS_PC || a == OFS_DEPTH || a == OFS_TOP;
	endfunction

	nnp_negate u_negate (
		.operand_i (DMEM_RDATA_I),
		.result_o  (neg_result),
		.flags_o   (neg_flags)
	);

	nnp_rstack #(
		.DEPTH (DEPTH),
		.WIDTH (PC_W)
	) u_rstack (
		.clk_i   (CLK_SYS_I),
		.rstn_i  (RSTN_I),
		.push_i  (push),
		.pop_i   (pop),
		.data_i  (PWDATA_I[PC_W-1:0]),
		.top_o   (stk_top),
		.count_o (stk_count),
		.full_o  (stk_full),
		.empty_o (stk_empty)
	);

	assign take = (state_reg == ST_Q1) && ready_reg && INSTR_VALID_I;
	assign pop  = (state_reg == ST_Q3) && (op_reg == OP_POP);

	// quarter-cycle sequencer: one instruction cycle per word
	always_comb begin
		case (state_reg)
			ST_Q1:   state_next = take ? ST_Q2 : ST_Q1;
			ST_Q2:   state_next = ST_Q3;
			ST_Q3:   state_next = ST_Q4;
			ST_Q4:   state_next = ST_Q1;
			default: state_next = ST_Q1;
		endcase
	end

	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state_reg <= ST_Q1;
			ready_reg <= 1'b1;
			done_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			ready_reg <= (state_next == ST_Q1);
			done_reg  <= (state_reg == ST_Q3);
		end
	end

	// decode quarter: latch word, form operand address
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			op_reg    <= OP_NOP;
			instr_reg <= '0;
			addr_reg  <= '0;
		end else if (take) begin
			op_reg    <= nnp_decode(INSTR_I);
			instr_reg <= INSTR_I;
			if (nnp_decode(INSTR_I) == OP_NEG)
				addr_reg <= nnp_form_addr(INSTR_I[8], INSTR_I[7:0], ext_reg,
					bank_reg, index_reg);
		end
	end

	// read in Q2, process in Q3, write in Q4
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rd_reg        <= 1'b0;
			wr_reg        <= 1'b0;
			wdata_reg     <= '0;
			flag_pend_reg <= '0;
		end else begin
			rd_reg <= take && (nnp_decode(INSTR_I) == OP_NEG);
			wr_reg <= (state_reg == ST_Q3) && (op_reg == OP_NEG);
			if (state_reg == ST_Q3 && op_reg == OP_NEG) begin
				wdata_reg     <= neg_result;
				flag_pend_reg <= neg_flags;
			end
		end
	end

	// arithmetic flags: negate commits at end of Q4, software may overwrite
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I)
			flags_reg <= STATUS_RST;
		else if (state_reg == ST_Q4 && op_reg == OP_NEG)
			flags_reg <= flag_pend_reg;
		else if (wr_commit && PADDR_I == OFS_STATUS)
			flags_reg <= PWDATA_I[FLAG_W-1:0];
	end

	// program counter advances once per executed word
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I)
			pc_reg <= PC_RST;
		else if (state_reg == ST_Q4)
			pc_reg <= pc_reg + PC_STEP;
	end

	// apb: one wait state; held off in Q2/Q3 so no write meets a pop or flag commit
	assign apb_go    = PSEL_I && PENABLE_I && !pready_reg &&
		state_reg != ST_Q2 && state_reg != ST_Q3;
	assign wr_commit = PSEL_I && PENABLE_I && pready_reg && PWRITE_I && !pslverr_reg;
	assign push      = wr_commit && (PADDR_I == OFS_TOP);

	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= '0;
		end else begin
			pready_reg  <= apb_go;
			pslverr_reg <= apb_go && (!reg_hit(PADDR_I));
			if (apb_go) begin
				case (PADDR_I)
					OFS_CTRL:   prdata_reg <= {31'h0, ext_reg};
					OFS_BANK:   prdata_reg <= {28'h0, bank_reg};
					OFS_INDEX:  prdata_reg <= {20'h0, index_reg};
					OFS_STATUS: prdata_reg <= {27'h0, flags_reg};
					OFS_EVENT:  prdata_reg <= {29'h0, evt_reg};
					OFS_PC:     prdata_reg <= {11'h0, pc_reg};
					OFS_DEPTH:  prdata_reg <= 32'(stk_count);
					OFS_TOP:    prdata_reg <= {11'h0, stk_top};
					default:    prdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ext_reg   <= CTRL_RST;
			bank_reg  <= BANK_RST;
			index_reg <= INDEX_RST;
		end else if (wr_commit) begin
			if (PADDR_I == OFS_CTRL)
				ext_reg <= PWDATA_I[CTRL_EXT];
			if (PADDR_I == OFS_BANK)
				bank_reg <= PWDATA_I[BANK_W-1:0];
			if (PADDR_I == OFS_INDEX)
				index_reg <= PWDATA_I[ADDR_W-1:0];
		end
	end

	// sticky events, write one to clear, a new event wins over the clear
	always_comb begin
		evt_set            = '0;
		evt_set[EVT_BAD]   = (state_reg == ST_Q4) && (op_reg == OP_BAD);
		evt_set[EVT_UNDER] = pop && stk_empty;
		evt_set[EVT_OVER]  = push && stk_full;
	end

	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I)
			evt_reg <= EVENT_RST;
		else if (wr_commit && PADDR_I == OFS_EVENT)
			evt_reg <= (evt_reg & ~PWDATA_I[EVT_W-1:0]) | evt_set;
		else
			evt_reg <= evt_reg | evt_set;
	end

	assign PRDATA_O      = prdata_reg;
	assign PREADY_O      = pready_reg;
	assign PSLVERR_O     = pslverr_reg;
	assign INSTR_READY_O = ready_reg;
	assign DMEM_ADDR_O   = addr_reg;
	assign DMEM_RD_O     = rd_reg;
	assign DMEM_WR_O     = wr_reg;
	assign DMEM_WDATA_O  = wdata_reg;
	assign DONE_O        = done_reg;

	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RSTN_I);

	AST_NEG_DECODE: assert property (take && INSTR_I[15:9] == NEG_OPC |=>
		op_reg == OP_NEG && rd_reg && addr_reg[7:0] == instr_reg[7:0])
		else $error("negate opcode not decoded");
	AST_NEG_VALUE: assert property ($rose(wr_reg) |->
		wdata_reg == DATA_W'(~$past(DMEM_RDATA_I) + 8'h01))
		else $error("negated value wrong");
	AST_SAME_ADDR: assert property (wr_reg |-> $past(rd_reg, 2) && $stable(addr_reg))
		else $error("write back not to the byte that was read");
	AST_ONE_CYCLE: assert property (take |=> state_reg == ST_Q2 ##1 state_reg == ST_Q3
		##1 (state_reg == ST_Q4 && done_reg) ##1 state_reg == ST_Q1)
		else $error("instruction not four quarters");
	AST_FLAGS: assert property (state_reg == ST_Q4 && op_reg == OP_NEG |=>
		flags_reg[FLG_Z] == (wdata_reg == 8'h00) && flags_reg[FLG_N] == wdata_reg[7] &&
		flags_reg[FLG_OVFL] == (wdata_reg == 8'h80))
		else $error("negate flags wrong");
	AST_BANK_ADDR: assert property (state_reg == ST_Q2 && op_reg == OP_NEG && instr_reg[8] |->
		addr_reg == {$past(bank_reg), instr_reg[7:0]})
		else $error("banked address wrong");
	AST_INDEXED: assert property (state_reg == ST_Q2 && op_reg == OP_NEG && !instr_reg[8] &&
		$past(ext_reg) && instr_reg[7:0] <= IDX_LIMIT |->
		addr_reg == $past(index_reg) + {ACC_LO, instr_reg[7:0]})
		else $error("indexed address wrong");
	AST_POP_QUIET: assert property (state_reg == ST_Q4 && op_reg == OP_POP |=>
		$stable(flags_reg) && !wr_reg)
		else $error("discard touched flags");
	AST_POP_DEPTH: assert property (pop && !stk_empty |=> stk_count == $past(stk_count) - 1'b1)
		else $error("discard did not drop the top");
	AST_NOP_QUIET: assert property (take && nnp_decode(INSTR_I) == OP_NOP |=>
		(!rd_reg && !wr_reg && $stable(flags_reg) && $stable(stk_count))[*4])
		else $error("no-operation changed state");
	AST_PC_STEP: assert property (state_reg == ST_Q4 |=> pc_reg == $past(pc_reg) + PC_STEP)
		else $error("program counter did not advance");

	COV_NEG: cover property (state_reg == ST_Q4 && op_reg == OP_NEG);
	COV_INDEXED: cover property (state_reg == ST_Q2 && op_reg == OP_NEG && !instr_reg[8] && ext_reg);
	COV_POP: cover property (pop && !stk_empty);
	COV_NOP: cover property (take && nnp_decode(INSTR_I) == OP_NOP);
endmodule
`default_nettype wire

// file: src/nnp_exec_end.sv
// empty compilation unit, holds no logic
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// file: tb/nnp_dmem_model.sv
// data memory seen by the executor, answering one cycle after a read strobe
`timescale 1ns/1ns
`default_nettype none
module nnp_dmem_model
	import nnp_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic              rd_i,
	input  wire logic              wr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	output logic      [DATA_W-1:0] rdata_o
);
	logic [DATA_W-1:0] mem [0:4095];

	initial rdata_o = 8'h00;

	always @(posedge clk_i) begin
		if (wr_i)
			mem[addr_i] <= wdata_i;
		// data valid only in the cycle after the strobe, scrambled otherwise
		if (rd_i)
			rdata_o <= mem[addr_i];
		else
			rdata_o <= ~rdata_o;
	end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench of the negate, no-operation and discard executor
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin \
	err_count++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module testbench;
	import nnp_pkg::*;
	logic               clk, rstn, psel, pen, pwr, pready, pslv, ivalid, iready;
	logic               drd, dwr, done;
	logic [APB_AW-1:0]  paddr;
	logic [31:0]        pwdata, prdata, rv;
	logic [INSTR_W-1:0] instr;
	logic [ADDR_W-1:0]  daddr;
	logic [DATA_W-1:0]  drdata, dwdata;
	int                 err_count, check_count, n_exec;

	nnp_exec i_nnp_exec (.CLK_SYS_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslv), .INSTR_VALID_I(ivalid), .INSTR_I(instr),
		.INSTR_READY_O(iready), .DMEM_ADDR_O(daddr), .DMEM_RD_O(drd),
		.DMEM_RDATA_I(drdata), .DMEM_WR_O(dwr), .DMEM_WDATA_O(dwdata), .DONE_O(done));
	nnp_dmem_model i_nnp_dmem_model (.clk_i(clk), .addr_i(daddr), .rd_i(drd), .wr_i(dwr),
		.wdata_i(dwdata), .rdata_o(drdata));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) err_count++;
		q = prdata;
		e = pslv;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd_chk(input logic [APB_AW-1:0] a, input logic [31:0] ex, input logic exe);
		logic e;
		apb(1'b0, a, 32'h0, rv, e);
		`CHK("prdata", ex, rv)
		`CHK("pslverr", exe, e)
	endtask

	// offers one word, then looks at the three cycles after it was taken
	task automatic exec(input logic [INSTR_W-1:0] w, input logic mem_op);
		int n;
		n = 0;
		ivalid <= 1'b1;
		instr <= w;
		do begin
			@(posedge clk);
			n++;
		end while (iready !== 1'b1 && n < 50);
		if (n >= 50) err_count++;
		ivalid <= 1'b0;
		n_exec++;
		for (int k = 1; k <= 3; k++) begin
			@(posedge clk);
			`CHK("rd", (k == 1) && mem_op, drd)
			`CHK("wr", (k == 3) && mem_op, dwr)
			`CHK("done", k == 3, done)
			`CHK("ready", 1'b0, iready)
		end
	endtask

	task automatic neg(input logic [INSTR_W-1:0] w, input logic [ADDR_W-1:0] a,
			input logic [7:0] x);
		logic [7:0] r;
		r = ~x + 8'h01;
		i_nnp_dmem_model.mem[a] = x;
		exec(w, 1'b1);
		`CHK("addr", a, daddr)
		`CHK("wdata", r, dwdata)
		rd_chk(OFS_STATUS, {27'h0, r[7], x == 8'h80, r == 8'h00, x[3:0] == 4'h0,
			x == 8'h00}, 1'b0);
		`CHK("mem", r, i_nnp_dmem_model.mem[a])
	endtask

	task automatic test_reset();
		for (int i = 0; i < 8; i++)
			rd_chk(APB_AW'(i * 4), 32'h0, 1'b0);
		rd_chk(12'h040, 32'h0, 1'b1);
		$display("test reset done");
	endtask

	task automatic test_neg_plain();
		wr(OFS_BANK, 32'h3);
		neg(16'h6d3a, 12'h33a, 8'h3a);
		neg(16'h6c10, 12'h010, 8'h80);
		neg(16'h6c80, 12'hf80, 8'h00);
		neg(16'h6c5f, 12'h05f, 8'h30);
		$display("test negate plain done");
	endtask

	task automatic test_neg_indexed();
		wr(OFS_CTRL, 32'h1);
		wr(OFS_INDEX, 32'h200);
		neg(16'h6c05, 12'h205, 8'h01);
		neg(16'h6c5f, 12'h25f, 8'hff);
		neg(16'h6c60, 12'hf60, 8'h7f);
		neg(16'h6d05, 12'h305, 8'h55);
		$display("test negate indexed done");
	endtask

	task automatic test_pop();
		logic [31:0] st;
		logic        e;
		apb(1'b0, OFS_STATUS, 32'h0, st, e);
		wr(OFS_TOP, 32'h1234);
		wr(OFS_TOP, 32'h15678);
		rd_chk(OFS_DEPTH, 32'h2, 1'b0);
		exec(POP_OPC, 1'b0);
		rd_chk(OFS_TOP, 32'h1234, 1'b0);
		rd_chk(OFS_DEPTH, 32'h1, 1'b0);
		rd_chk(OFS_STATUS, st, 1'b0);
		$display("test discard done");
	endtask

	task automatic test_nop();
		logic [31:0] st;
		logic        e;
		apb(1'b0, OFS_STATUS, 32'h0, st, e);
		i_nnp_dmem_model.mem[12'h000] = 8'h5a;
		exec(16'h0000, 1'b0);
		exec(16'hf123, 1'b0);
		rd_chk(OFS_STATUS, st, 1'b0);
		rd_chk(OFS_DEPTH, 32'h1, 1'b0);
		rd_chk(OFS_TOP, 32'h1234, 1'b0);
		`CHK("mem0", 8'h5a, i_nnp_dmem_model.mem[12'h000])
		rd_chk(OFS_PC, 32'(n_exec * 2), 1'b0);
		$display("test nop done");
	endtask

	// unknown opcode, discard on empty stack and push on full stack raise events
	task automatic test_events();
		exec(16'h0123, 1'b0);
		exec(POP_OPC, 1'b0);
		exec(POP_OPC, 1'b0);
		rd_chk(OFS_DEPTH, 32'h0, 1'b0);
		rd_chk(OFS_TOP, 32'h0, 1'b0);
		rd_chk(OFS_EVENT, 32'h3, 1'b0);
		for (int i = 0; i <= STACK_DEPTH; i++)
			wr(OFS_TOP, 32'(i));
		rd_chk(OFS_DEPTH, 32'(STACK_DEPTH), 1'b0);
		rd_chk(OFS_TOP, 32'(STACK_DEPTH - 1), 1'b0);
		rd_chk(OFS_EVENT, 32'h7, 1'b0);
		wr(OFS_EVENT, 32'h7);
		rd_chk(OFS_EVENT, 32'h0, 1'b0);
		$display("test events done");
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		{rstn, psel, pen, pwr, ivalid} = 5'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		instr = 16'h0000;
		err_count = 0;
		check_count = 0;
		n_exec = 0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		test_reset();
		test_neg_plain();
		test_neg_indexed();
		test_pop();
		test_nop();
		test_events();
		test_done();
	end

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		test_done();
	end
endmodule
`default_nettype wire
